// File: hdl/servo_home_ctrl.sv
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "servo_home_defines.svh"
module servo_home_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic origin_switch_input,
    input wire logic homing_start_input,
    input wire logic index_pulse,
    input wire logic encoder_step,
    output servo_home_pkg::motor_cmd_type motor_cmd,
    output logic homing_busy,
    output logic reference_set,
    output logic signed [31:0] current_position
);
    logic [15:0] search_speed_q;
    logic [15:0] leave_speed_q;
    logic [15:0] teach_high_q;
    logic [15:0] teach_low_q;
    logic [15:0] homing_mode_q;
    logic [15:0] offset_high_q;
    logic [15:0] offset_low_q;
    servo_home_pkg::home_mode_type mode_q;
    servo_home_pkg::home_state_type state_q;
    servo_home_pkg::home_state_type state_d;
    logic load_mode_q;
    logic ref_set_q;
    logic [31:0] step_count_q;
    logic signed [31:0] position_q;
    logic signed [31:0] teach_value;
    logic signed [31:0] offset_value;
    logic [31:0] offset_dist;
    logic [3:0] pins_sync;
    logic start_s;
    logic origin_s;
    logic index_s;
    logic step_s;
    logic start_prev_q;
    logic index_prev_q;
    logic step_prev_q;
    logic start_rise;
    logic index_rise;
    logic step_rise;
    logic wr_en;
    logic rd_en;
    logic addr_hit;
    logic teach_cmd;
    logic restart_cmd;
    logic abort_cmd;

    // magnitude of a signed pulse count
    function automatic logic [31:0] magnitude(input logic signed [31:0] v);
        magnitude = v[31] ? 32'(-v) : 32'(v);
    endfunction : magnitude

    // pins come from the motor side, not from this clock
    in_sync #(.WIDTH(4)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({encoder_step, index_pulse, origin_switch_input,
            homing_start_input}),
        .sync_out(pins_sync)
    );
    assign start_s = pins_sync[0];
    assign origin_s = pins_sync[1];
    assign index_s = pins_sync[2];
    assign step_s = pins_sync[3];

    pulse_combine u_teach (
        .high_part(teach_high_q),
        .low_part(teach_low_q),
        .total(teach_value)
    );

    pulse_combine u_offset (
        .high_part(offset_high_q),
        .low_part(offset_low_q),
        .total(offset_value)
    );
    assign offset_dist = magnitude(offset_value);

    // edge detection on synchronised inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_prev_q <= 1'b0;
            index_prev_q <= 1'b0;
            step_prev_q <= 1'b0;
        end else begin
            start_prev_q <= start_s;
            index_prev_q <= index_s;
            step_prev_q <= step_s;
        end
    end
    assign start_rise = start_s && !start_prev_q;
    assign index_rise = index_s && !index_prev_q;
    assign step_rise = step_s && !step_prev_q;

    // apb decode, zero wait states
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    always_comb begin
        case (paddr)
            `OFS_SEARCH_SPEED, `OFS_LEAVE_SPEED, `OFS_TEACH_HIGH,
            `OFS_TEACH_LOW, `OFS_HOMING_MODE, `OFS_OFFSET_HIGH,
            `OFS_OFFSET_LOW, `OFS_CONTROL, `OFS_STATUS,
            `OFS_POSITION: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_hit;
    assign teach_cmd = wr_en && paddr == `OFS_CONTROL
        && pwdata[`FLD_CTL_TEACH];
    assign restart_cmd = wr_en && paddr == `OFS_CONTROL
        && pwdata[`FLD_CTL_RESTART];
    assign abort_cmd = wr_en && paddr == `OFS_CONTROL
        && pwdata[`FLD_CTL_ABORT];

    // setting registers, speeds and counts act as soon as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            search_speed_q <= `RST_SEARCH_SPEED;
            leave_speed_q <= `RST_LEAVE_SPEED;
            teach_high_q <= `RST_ZERO16;
            teach_low_q <= `RST_ZERO16;
            homing_mode_q <= `RST_ZERO16;
            offset_high_q <= `RST_ZERO16;
            offset_low_q <= `RST_ZERO16;
        end else if (wr_en) begin
            case (paddr)
                `OFS_SEARCH_SPEED: search_speed_q <= pwdata[15:0];
                `OFS_LEAVE_SPEED: leave_speed_q <= pwdata[15:0];
                `OFS_TEACH_HIGH: teach_high_q <= pwdata[15:0];
                `OFS_TEACH_LOW: teach_low_q <= pwdata[15:0];
                `OFS_HOMING_MODE: homing_mode_q <= pwdata[15:0];
                `OFS_OFFSET_HIGH: offset_high_q <= pwdata[15:0];
                `OFS_OFFSET_LOW: offset_low_q <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // mode in effect changes only at a restart, once after reset too
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_mode_q <= 1'b1;
            mode_q <= '0;
        end else begin
            load_mode_q <= 1'b0;
            if (load_mode_q || restart_cmd) begin
                mode_q.home_dir <= homing_mode_q[`FLD_HOME_DIR];
                mode_q.index_style <= homing_mode_q[`FLD_INDEX_STYLE];
                mode_q.trigger <= homing_mode_q[`FLD_TRIGGER];
            end
        end
    end

    // read mux; reserved bits read zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `OFS_SEARCH_SPEED: prdata[15:0] = search_speed_q;
                `OFS_LEAVE_SPEED: prdata[15:0] = leave_speed_q;
                `OFS_TEACH_HIGH: prdata[15:0] = teach_high_q;
                `OFS_TEACH_LOW: prdata[15:0] = teach_low_q;
                `OFS_HOMING_MODE: prdata[15:0] = homing_mode_q;
                `OFS_OFFSET_HIGH: prdata[15:0] = offset_high_q;
                `OFS_OFFSET_LOW: prdata[15:0] = offset_low_q;
                `OFS_STATUS: prdata[7:0] = {mode_q, state_q, ref_set_q,
                    homing_busy};
                `OFS_POSITION: prdata = position_q;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // homing sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            servo_home_pkg::ST_IDLE:
                if (mode_q.trigger && start_rise) begin
                    state_d = servo_home_pkg::ST_APPROACH;
                end
            servo_home_pkg::ST_APPROACH:
                if (origin_s) begin
                    state_d = servo_home_pkg::ST_LEAVE;
                end
            servo_home_pkg::ST_LEAVE:
                if (!origin_s) begin
                    state_d = servo_home_pkg::ST_INDEX;
                end
            servo_home_pkg::ST_INDEX:
                if (index_rise) begin
                    state_d = servo_home_pkg::ST_OFFSET;
                end
            servo_home_pkg::ST_OFFSET:
                if (step_count_q >= offset_dist) begin
                    state_d = servo_home_pkg::ST_DONE;
                end
            servo_home_pkg::ST_DONE:
                state_d = servo_home_pkg::ST_IDLE;
            default:
                state_d = servo_home_pkg::ST_IDLE;
        endcase
        if (abort_cmd) begin
            state_d = servo_home_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= servo_home_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // offset steps counted only in the offset phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_count_q <= 32'h0000_0000;
        end else if (state_q != servo_home_pkg::ST_OFFSET) begin
            step_count_q <= 32'h0000_0000;
        end else if (step_rise) begin
            step_count_q <= step_count_q + 32'h0000_0001;
        end
    end

    // reference flag: set in the done phase, cleared only when a new homing run starts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_set_q <= 1'b0;
        end else if (state_q == servo_home_pkg::ST_DONE) begin
            ref_set_q <= 1'b1;
        end else if (state_d == servo_home_pkg::ST_APPROACH) begin
            ref_set_q <= 1'b0;
        end
    end

    // speed and direction per phase; leaving runs against homing direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_cmd <= '0;
        end else begin
            motor_cmd.run <= 1'b1;
            case (state_d)
                servo_home_pkg::ST_APPROACH: begin
                    motor_cmd.reverse <= mode_q.home_dir;
                    motor_cmd.speed_rpm <= search_speed_q;
                end
                servo_home_pkg::ST_LEAVE: begin
                    motor_cmd.reverse <= !mode_q.home_dir;
                    motor_cmd.speed_rpm <= leave_speed_q;
                end
                servo_home_pkg::ST_INDEX: begin
                    // style 0 turns back toward the switch side
                    motor_cmd.reverse <= mode_q.index_style ?
                        !mode_q.home_dir : mode_q.home_dir;
                    motor_cmd.speed_rpm <= leave_speed_q;
                end
                servo_home_pkg::ST_OFFSET: begin
                    motor_cmd.reverse <= offset_value[31];
                    motor_cmd.speed_rpm <= leave_speed_q;
                end
                default: begin
                    motor_cmd.run <= 1'b0;
                    motor_cmd.reverse <= 1'b0;
                    motor_cmd.speed_rpm <= 16'h0000;
                end
            endcase
        end
    end

    // position: teach load wins over step tracking; zero at reference
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position_q <= 32'sh0000_0000;
        end else if (teach_cmd && state_q == servo_home_pkg::ST_IDLE) begin
            position_q <= teach_value;
        end else if (state_q == servo_home_pkg::ST_DONE) begin
            position_q <= 32'sh0000_0000;
        end else if (step_rise && motor_cmd.run) begin
            position_q <= motor_cmd.reverse ? position_q - 32'sd1
                : position_q + 32'sd1;
        end
    end

    assign homing_busy = state_q != servo_home_pkg::ST_IDLE;
    assign reference_set = ref_set_q;
    assign current_position = position_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_approach_end;
        state_q == servo_home_pkg::ST_APPROACH && origin_s && !abort_cmd;
    endsequence
    sequence s_leave_start;
        state_q == servo_home_pkg::ST_LEAVE;
    endsequence

    a_dir_approach: assert property (
        state_q == servo_home_pkg::ST_APPROACH && !abort_cmd ##1
        state_q == servo_home_pkg::ST_APPROACH
        |-> motor_cmd.run && motor_cmd.reverse == mode_q.home_dir)
        else $error("approach direction wrong");
    a_index_style: assert property (
        state_q == servo_home_pkg::ST_INDEX && state_d == state_q
        |=> motor_cmd.reverse == (mode_q.index_style ^ mode_q.home_dir))
        else $error("index search direction wrong");
    a_trigger_off: assert property (
        state_q == servo_home_pkg::ST_IDLE && !mode_q.trigger
        |=> state_q == servo_home_pkg::ST_IDLE)
        else $error("homing left idle while disabled");
    a_start_edge: assert property (
        state_q == servo_home_pkg::ST_IDLE && mode_q.trigger && start_rise
        && !abort_cmd |=> state_q == servo_home_pkg::ST_APPROACH)
        else $error("start edge missed");
    a_search_speed: assert property (
        state_q == servo_home_pkg::ST_APPROACH && $stable(state_q)
        && $stable(search_speed_q)
        |-> motor_cmd.speed_rpm == search_speed_q)
        else $error("search speed wrong");
    a_leave_speed: assert property (
        s_approach_end |=> s_leave_start ##0
        motor_cmd.speed_rpm == leave_speed_q)
        else $error("leave speed wrong");
    a_teach_sum: assert property (
        $rose(teach_cmd) |-> teach_value ==
        32'($signed(teach_high_q)) * 32'sh0000_2710
        + 32'($signed(teach_low_q)))
        else $error("taught value not combined");
    a_teach_load: assert property (
        teach_cmd && state_q == servo_home_pkg::ST_IDLE
        |=> position_q == $past(teach_value))
        else $error("teach did not load position");
    a_offset_done: assert property (
        state_q == servo_home_pkg::ST_OFFSET && step_count_q >= offset_dist
        && !abort_cmd |=> state_q == servo_home_pkg::ST_DONE ##1
        ref_set_q && position_q == 32'sh0000_0000)
        else $error("offset end not reached");
    a_seq_order: assert property (
        $rose(state_q == servo_home_pkg::ST_OFFSET)
        |-> $past(state_q) == servo_home_pkg::ST_INDEX)
        else $error("homing phases out of order");
    a_mode_hold: assert property (
        !load_mode_q && !restart_cmd |=> $stable(mode_q))
        else $error("mode changed without restart");
endmodule : servo_home_ctrl

// File: hdl/servo_home_defines.svh
`ifndef SERVO_HOME_DEFINES_SVH
`define SERVO_HOME_DEFINES_SVH

// register byte offsets
`define OFS_SEARCH_SPEED 8'h00
`define OFS_LEAVE_SPEED 8'h04
`define OFS_TEACH_HIGH 8'h08
`define OFS_TEACH_LOW 8'h0C
`define OFS_HOMING_MODE 8'h10
`define OFS_OFFSET_HIGH 8'h14
`define OFS_OFFSET_LOW 8'h18
`define OFS_CONTROL 8'h1C
`define OFS_STATUS 8'h20
`define OFS_POSITION 8'h24

// field positions in the mode setting and control word
`define FLD_HOME_DIR 0
`define FLD_INDEX_STYLE 1
`define FLD_TRIGGER 2
`define FLD_CTL_TEACH 0
`define FLD_CTL_RESTART 1
`define FLD_CTL_ABORT 2

// reset values
`define RST_SEARCH_SPEED 16'h0064
`define RST_LEAVE_SPEED 16'h000A
`define RST_ZERO16 16'h0000

// weight of the high half of a split pulse count
`define PULSE_HIGH_WEIGHT 32'sh0000_2710

`endif

// File: hdl/servo_home_pkg.sv
package servo_home_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_APPROACH,
        ST_LEAVE,
        ST_INDEX,
        ST_OFFSET,
        ST_DONE
    } home_state_type;

    // command presented to the motor speed loop
    typedef struct packed {
        logic run;
        logic reverse;
        logic [15:0] speed_rpm;
    } motor_cmd_type;

    // homing mode fields as held in effect
    typedef struct packed {
        logic trigger;
        logic index_style;
        logic home_dir;
    } home_mode_type;

endpackage : servo_home_pkg

// File: hdl/in_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for asynchronous pin inputs
module in_sync #(
    parameter int WIDTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : in_sync

// File: hdl/pulse_combine.sv
`timescale 1ns/1ps
`include "servo_home_defines.svh"
// signed high and low halves into one pulse count
module pulse_combine (
    input wire logic [15:0] high_part,
    input wire logic [15:0] low_part,
    output logic signed [31:0] total
);
    logic signed [31:0] high_ext;
    logic signed [31:0] low_ext;

    // both halves are signed, high weighs ten thousand pulses
    assign high_ext = 32'($signed(high_part));
    assign low_ext = 32'($signed(low_part));
    assign total = high_ext * `PULSE_HIGH_WEIGHT + low_ext;
endmodule : pulse_combine

// File: tb/motor_model.sv
`timescale 1ns/1ps
// shaft with encoder, index mark and origin switch bands
module motor_model #(
    parameter int STEP_DIV = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire servo_home_pkg::motor_cmd_type motor_cmd,
    input wire logic park,
    output logic origin_switch_input,
    output logic index_pulse,
    output logic encoder_step,
    output int pos,
    output int index_pos
);
    int div_q;
    logic idx_prev_q;

    // one step per STEP_DIV cycles; slow enough that the
    // two-cycle input sync never lags a whole step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 0;
            pos <= 0;
            encoder_step <= 1'b0;
        end else begin
            encoder_step <= 1'b0;
            if (park) begin
                pos <= 0;
                div_q <= 0;
            end else if (motor_cmd.run) begin
                div_q <= (div_q == STEP_DIV - 1) ? 0 : div_q + 1;
                if (div_q == STEP_DIV - 1) begin
                    encoder_step <= 1'b1;
                    pos <= motor_cmd.reverse ? pos - 1 : pos + 1;
                end
            end
        end
    end

    // switch bands on both sides of zero, index at 8 mod 16
    assign origin_switch_input = (pos >= 40 && pos < 64) ||
                                 (pos <= -40 && pos > -64);
    assign index_pulse = (((pos % 16) + 16) % 16) == 8;

    // remember where the index mark was last met
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_prev_q <= 1'b0;
            index_pos <= 0;
        end else begin
            idx_prev_q <= index_pulse;
            if (index_pulse && !idx_prev_q) begin
                index_pos <= pos;
            end
        end
    end
endmodule : motor_model

// File: tb/servo_home_ctrl_tb.sv
`timescale 1ns/1ps
module servo_home_ctrl_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, origin_switch_input, index_pulse, encoder_step;
    logic homing_start_input = 1'b0;
    logic park = 1'b0;
    logic homing_busy, reference_set;
    logic signed [31:0] current_position;
    servo_home_pkg::motor_cmd_type motor_cmd;
    int pos, index_pos;
    int err_count = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic er;

    always #2.5 pclk = ~pclk;

    servo_home_ctrl servo_home_ctrl_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .origin_switch_input(origin_switch_input),
        .homing_start_input(homing_start_input),
        .index_pulse(index_pulse), .encoder_step(encoder_step),
        .motor_cmd(motor_cmd), .homing_busy(homing_busy),
        .reference_set(reference_set),
        .current_position(current_position));

    motor_model motor_model_i (.pclk(pclk), .presetn(presetn),
        .motor_cmd(motor_cmd), .park(park),
        .origin_switch_input(origin_switch_input),
        .index_pulse(index_pulse), .encoder_step(encoder_step),
        .pos(pos), .index_pos(index_pos));

    task chk(input logic [31:0] got, input logic [31:0] exp,
             input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // one apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task start_pulse();
        @(posedge pclk);
        homing_start_input <= 1'b1;
        repeat (4) @(posedge pclk);
        homing_start_input <= 1'b0;
    endtask : start_pulse

    task wait_state(input logic [2:0] st);
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[4:2] !== st && n < 400) begin
            apb(1'b0, 8'h20, 32'h0, rd, er);
            n++;
        end
        chk({29'h0, rd[4:2]}, {29'h0, st}, "phase");
    endtask : wait_state

    task test_reset();
        apb(1'b0, 8'h00, 32'h0, rd, er);
        chk(rd, 32'h00000064, "search speed reset");
        apb(1'b0, 8'h04, 32'h0, rd, er);
        chk(rd, 32'h0000000A, "leave speed reset");
        apb(1'b0, 8'h30, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1, "unmapped error");
        $display("test reset done");
    endtask : test_reset

    task test_teach();
        int t;
        t = int'($signed(16'hFFFE)) * 10000 + int'($signed(16'h0005));
        apb(1'b1, 8'h08, 32'h0000FFFE, rd, er);
        apb(1'b1, 8'h0C, 32'h00000005, rd, er);
        apb(1'b1, 8'h1C, 32'h00000001, rd, er);
        apb(1'b0, 8'h24, 32'h0, rd, er);
        chk(rd, t, "taught position read");
        chk(current_position, t, "taught position port");
        $display("test teach done");
    endtask : test_teach

    // start must be ignored while the trigger in effect is off
    task test_trigger_off();
        logic moved;
        moved = 1'b0;
        start_pulse();
        repeat (20) @(posedge pclk) moved |= (homing_busy !== 1'b0);
        chk({31'h0, moved}, 32'h0, "start while disabled");
        apb(1'b1, 8'h10, 32'h00000004, rd, er);
        start_pulse();
        repeat (20) @(posedge pclk) moved |= (homing_busy !== 1'b0);
        chk({31'h0, moved}, 32'h0, "mode before restart");
        $display("test trigger off done");
    endtask : test_trigger_off

    task home_case(input logic dir, input logic style,
                   input logic [15:0] off);
        int n;
        @(posedge pclk);
        park <= 1'b1;
        @(posedge pclk);
        park <= 1'b0;
        apb(1'b1, 8'h10, {29'h0, 1'b1, style, dir}, rd, er);
        apb(1'b1, 8'h1C, 32'h00000002, rd, er);
        apb(1'b1, 8'h18, {16'h0, off}, rd, er);
        start_pulse();
        wait_state(3'h1);
        chk(motor_cmd, {1'b1, dir, 16'h0123}, "approach cmd");
        wait_state(3'h2);
        chk(motor_cmd, {1'b1, ~dir, 16'h000A}, "leave cmd");
        wait_state(3'h3);
        chk(motor_cmd, {1'b1, style ^ dir, 16'h000A}, "index cmd");
        wait_state(3'h4);
        chk(motor_cmd, {1'b1, off[15], 16'h000A}, "offset cmd");
        n = 0;
        while (homing_busy !== 1'b0 && n < 1000) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, reference_set}, 32'h1, "reference set");
        chk(current_position, 32'h0, "position zeroed");
        chk({31'h0, motor_cmd.run}, 32'h0, "motor stopped");
        chk(pos - index_pos, int'($signed(off)), "offset travel");
        $display("test homing dir %0d style %0d done", dir, style);
    endtask : home_case

    // abort in approach stops the motor; teach is refused while busy
    task test_abort();
        @(posedge pclk);
        park <= 1'b1;
        @(posedge pclk);
        park <= 1'b0;
        start_pulse();
        wait_state(3'h1);
        apb(1'b1, 8'h1C, 32'h00000001, rd, er);
        rd = {31'h0, current_position == 32'hFFFF_B1E5};
        chk(rd, 32'h0, "teach while busy");
        apb(1'b1, 8'h1C, 32'h00000004, rd, er);
        apb(1'b0, 8'h20, 32'h0, rd, er);
        chk(rd, 32'h000000E0, "status after abort");
        chk({31'h0, motor_cmd.run}, 32'h0, "motor stopped on abort");
        chk({31'h0, reference_set}, 32'h0, "no reference on abort");
        $display("test abort done");
    endtask : test_abort

    task print_verdict();
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        test_reset();
        test_teach();
        test_trigger_off();
        apb(1'b1, 8'h00, 32'h00000123, rd, er);
        home_case(1'b0, 1'b0, 16'h0003);
        home_case(1'b1, 1'b1, 16'hFFFE);
        test_abort();
        print_verdict();
    end

    // a hang anywhere ends the run as a failure
    initial begin
        repeat (30000) @(posedge pclk);
        err_count++;
        $display("Error %0t: watchdog expired", $time);
        print_verdict();
    end
endmodule : servo_home_ctrl_tb
